// ==== core/ssc_pkg.sv ====
// Contract
// RQ1 - Line valid is high exactly while valid pixel words sit on the data outputs.
// RQ2 - Frame valid is high for the whole readout of a valid frame.
// RQ3 - Master mode: sensor drives main integration line high during integration.
// RQ4 - Slave mode: controller drives main integration line high for desired integration.
// RQ5 - Dual-slope line active high; sensor drives in master, controller in slave.
// RQ6 - Triple-slope line active high; sensor drives in master, controller in slave.
// RQ7 - Controller resets the sequencer by driving its low-active reset low.
// RQ8 - Controller supplies a nominal 80 MHz readout clock, sine or square.
// RQ9 - Controller keeps the serial configuration clock at or below 20 MHz.
// RQ10 - Serial data line is shared; each side releases it while the other drives.
// RQ11 - All pixels integrate light during the same period.
// RQ12 - The whole pixel array is reset at one instant when exposure starts.
// RQ13 - All pixel values move to in-pixel storage at one instant when integration ends.
// RQ14 - The stored array is read out one row at a time in sequence.
// RQ15 - Integration and readout may overlap or run one after the other.
// RQ16 - Master select 1 (default) times everything; 0 lets pins time integration.
// RQ17 - Controller rewrites configuration only while frame valid is low.
// RQ18 - Master select and granularity change only while sequencer reset is low.
// RQ19 - The sequencer runs at the readout clock divided by four.
// RQ20 - Line valid is asserted only while frame valid is asserted.
package ssc_pkg;
	localparam int SEQ_DIV = 4;
	localparam logic [1:0] SEQ_DIV_LAST = 2'h3;
	localparam int ROWS_DEF = 480;
	localparam int KERNELS_DEF = 160;
	localparam int ROW_GAP_DEF = 8;
	localparam int FRAME_GAP_DEF = 48;
	localparam int INT1_DEF = 1000;
	localparam int INT2_DEF = 200;
	localparam int INT3_DEF = 50;
	localparam logic MASTER_RESET_VAL = 1'b1;
	typedef enum logic [2:0] {
		SSC_IDLE = 3'b000,
		SSC_FOT = 3'b001,
		SSC_ROW_GAP = 3'b010,
		SSC_ROW_DATA = 3'b011,
		SSC_DONE = 3'b100
	} ssc_rd_state_t;
endpackage

// ==== core/ssc_top.sv ====
`timescale 1ns/10ps
module ssc_top
	import ssc_pkg::*;
#(
	parameter int ROWS = ssc_pkg::ROWS_DEF,
	parameter int KERNELS = ssc_pkg::KERNELS_DEF,
	parameter int ROW_GAP = ssc_pkg::ROW_GAP_DEF,
	parameter int FRAME_GAP = ssc_pkg::FRAME_GAP_DEF,
	parameter int INT1_TICKS = ssc_pkg::INT1_DEF,
	parameter int INT2_TICKS = ssc_pkg::INT2_DEF,
	parameter int INT3_TICKS = ssc_pkg::INT3_DEF
)(
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic SEQ_RESET_N_IN,
	input wire logic MASTER_MODE_IN,
	input wire logic PARALLEL_MODE_IN,
	input wire logic INT_MAIN_IN,
	input wire logic INT_DUAL_IN,
	input wire logic INT_TRIPLE_IN,
	input wire logic [9:0] PIX_DATA_IN,
	input wire logic RX_READY_IN,
	output logic INT_MAIN_OUT,
	output logic INT_DUAL_OUT,
	output logic INT_TRIPLE_OUT,
	output logic INT_OE_N_OUT,
	output logic ARRAY_RESET_OUT,
	output logic ARRAY_SAMPLE_OUT,
	output logic [9:0] PIX_DATA_OUT,
	output logic LINE_VALID_OUT,
	output logic FRAME_VALID_OUT
);
	import ssc_pkg::*;

	initial
	begin
		if (ROWS < 1 || KERNELS < 1 || ROW_GAP < 1 || FRAME_GAP < 1 || INT1_TICKS < 2)
			$error("ssc_top: counts must be positive");
		if (INT2_TICKS >= INT1_TICKS || INT3_TICKS >= INT2_TICKS)
			$error("ssc_top: slope windows must nest inside the main window");
	end

	// Sequencer tick: one pulse every fourth core clock.
	logic [1:0] div_q, div_d;
	logic tick;
	always_comb
	begin
		div_d = div_q + 2'h1;
		if (!SEQ_RESET_N_IN)
			div_d = 2'h0;
	end
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			div_q <= 2'h0;
		else
			div_q <= div_d; // RQ19
	end
	assign tick = (div_q == SEQ_DIV_LAST);

	// Master select is latched only while the sequencer is held in reset, so a change mid-frame is ignored.
	logic master_q, master_d;
	always_comb
	begin
		master_d = master_q;
		if (!SEQ_RESET_N_IN)
			master_d = MASTER_MODE_IN; // RQ16
	end
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			master_q <= MASTER_RESET_VAL;
		else
			master_q <= master_d;
	end

	// Exposure timing; in master mode an internal counter, in slave mode the three pins.
	logic [31:0] exp_cnt_q, exp_cnt_d;
	logic int1_q, int1_d, int2_q, int2_d, int3_q, int3_d;
	logic int_prev_q, int_prev_d;
	logic arr_rst_q, arr_rst_d, arr_smp_q, arr_smp_d;
	logic frame_req_q, frame_req_d;
	logic busy;
	logic int_now;
	always_comb
	begin
		exp_cnt_d = exp_cnt_q;
		int1_d = int1_q;
		int2_d = int2_q;
		int3_d = int3_q;
		arr_rst_d = 1'b0;
		arr_smp_d = 1'b0;
		frame_req_d = frame_req_q;
		int_now = int1_q;
		if (master_q)
		begin
			if (tick)
			begin
				// Sequential mode waits for readout to finish before starting a new exposure.
				if (!int1_q && (PARALLEL_MODE_IN || !busy) && !frame_req_q) // RQ15
				begin
					int1_d = 1'b1; // RQ3
					exp_cnt_d = 32'h0;
					arr_rst_d = 1'b1; // RQ12
				end
				else if (int1_q)
				begin
					exp_cnt_d = exp_cnt_q + 32'h1;
					// Compare the updated count, so the slope windows last the full INT2 and INT3 ticks.
					int2_d = (exp_cnt_d >= 32'(INT1_TICKS - INT2_TICKS)); // RQ5
					int3_d = (exp_cnt_d >= 32'(INT1_TICKS - INT3_TICKS)); // RQ6
					if (exp_cnt_q == 32'(INT1_TICKS - 1))
					begin
						int1_d = 1'b0;
						int2_d = 1'b0;
						int3_d = 1'b0;
					end
				end
			end
		end
		else
		begin
			int_now = INT_MAIN_IN; // RQ4
			int1_d = INT_MAIN_IN;
			int2_d = INT_DUAL_IN; // RQ5
			int3_d = INT_TRIPLE_IN; // RQ6
			if (INT_MAIN_IN && !int_prev_q)
				arr_rst_d = 1'b1; // RQ12
		end
		if (frame_req_q && !busy)
			frame_req_d = 1'b0;
		// Falling edge of the window samples every pixel at once and queues a readout; a new request wins over the clear.
		if (int_prev_q && !int_now)
		begin
			arr_smp_d = 1'b1; // RQ13
			frame_req_d = 1'b1; // RQ11
		end
		if (!SEQ_RESET_N_IN)
		begin
			exp_cnt_d = 32'h0;
			int1_d = 1'b0;
			int2_d = 1'b0;
			int3_d = 1'b0;
			frame_req_d = 1'b0;
		end
	end
	always_comb
	begin
		int_prev_d = master_q ? int1_q : INT_MAIN_IN;
		if (!SEQ_RESET_N_IN)
			int_prev_d = 1'b0;
	end
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			exp_cnt_q <= 32'h0;
			int1_q <= 1'b0;
			int2_q <= 1'b0;
			int3_q <= 1'b0;
			int_prev_q <= 1'b0;
			arr_rst_q <= 1'b0;
			arr_smp_q <= 1'b0;
			frame_req_q <= 1'b0;
		end
		else
		begin
			exp_cnt_q <= exp_cnt_d;
			int1_q <= int1_d;
			int2_q <= int2_d;
			int3_q <= int3_d;
			int_prev_q <= int_prev_d;
			arr_rst_q <= arr_rst_d;
			arr_smp_q <= arr_smp_d;
			frame_req_q <= frame_req_d;
		end
	end

	// Readout sequencer: overhead, then rows one at a time, each with a gap then pixel words.
	ssc_rd_state_t st_q, st_d;
	logic [31:0] row_q, row_d, cnt_q, cnt_d;
	logic push;
	logic buf_ready;
	logic frame_d;
	always_comb
	begin
		st_d = st_q;
		row_d = row_q;
		cnt_d = cnt_q;
		push = 1'b0;
		case (st_q)
			SSC_IDLE:
				if (frame_req_q)
				begin
					st_d = SSC_FOT;
					cnt_d = 32'h0;
					row_d = 32'h0;
				end
			SSC_FOT:
				if (tick)
				begin
					cnt_d = cnt_q + 32'h1;
					if (cnt_q == 32'(FRAME_GAP - 1))
					begin
						st_d = SSC_ROW_GAP;
						cnt_d = 32'h0;
					end
				end
			SSC_ROW_GAP:
				if (tick)
				begin
					cnt_d = cnt_q + 32'h1;
					if (cnt_q == 32'(ROW_GAP - 1))
					begin
						st_d = SSC_ROW_DATA;
						cnt_d = 32'h0;
					end
				end
			SSC_ROW_DATA:
				// Four pixels per kernel, one per core clock; a full buffer stalls the row.
				if (buf_ready)
				begin
					push = 1'b1;
					cnt_d = cnt_q + 32'h1;
					if (cnt_q == 32'(KERNELS * SEQ_DIV - 1))
					begin
						cnt_d = 32'h0;
						row_d = row_q + 32'h1; // RQ14
						st_d = (row_q == 32'(ROWS - 1)) ? SSC_DONE : SSC_ROW_GAP;
					end
				end
			SSC_DONE:
				st_d = SSC_IDLE;
			default:
				st_d = SSC_IDLE;
		endcase
		if (!SEQ_RESET_N_IN)
			st_d = SSC_IDLE;
	end
	assign busy = (st_q != SSC_IDLE);
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			st_q <= SSC_IDLE;
			row_q <= 32'h0;
			cnt_q <= 32'h0;
		end
		else
		begin
			st_q <= st_d;
			row_q <= row_d;
			cnt_q <= cnt_d;
		end
	end

	// Two-entry skid buffer between the pixel stream and the receiver.
	logic [9:0] b0_q, b0_d, b1_q, b1_d;
	logic [1:0] fill_q, fill_d;
	logic pop;
	assign buf_ready = (fill_q != 2'h2);
	assign pop = (fill_q != 2'h0) && RX_READY_IN;
	always_comb
	begin
		b0_d = b0_q;
		b1_d = b1_q;
		fill_d = fill_q;
		case ({push, pop})
			2'b10:
			begin
				if (fill_q == 2'h0)
					b0_d = PIX_DATA_IN;
				else
					b1_d = PIX_DATA_IN;
				fill_d = fill_q + 2'h1;
			end
			2'b01:
			begin
				b0_d = b1_q;
				fill_d = fill_q - 2'h1;
			end
			2'b11:
				if (fill_q == 2'h1)
					b0_d = PIX_DATA_IN;
				else
				begin
					b0_d = b1_q;
					b1_d = PIX_DATA_IN;
				end
			default:
				fill_d = fill_q;
		endcase
		if (!SEQ_RESET_N_IN)
			fill_d = 2'h0;
	end
	// Frame valid covers the readout and stays until the buffer has drained.
	assign frame_d = (st_q == SSC_ROW_GAP || st_q == SSC_ROW_DATA || fill_d != 2'h0) && SEQ_RESET_N_IN;
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			b0_q <= 10'h000;
			b1_q <= 10'h000;
			fill_q <= 2'h0;
		end
		else
		begin
			b0_q <= b0_d;
			b1_q <= b1_d;
			fill_q <= fill_d;
		end
	end

	// Output registers; line valid mirrors buffer occupancy, so it is high exactly with a word.
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			INT_MAIN_OUT <= 1'b0;
			INT_DUAL_OUT <= 1'b0;
			INT_TRIPLE_OUT <= 1'b0;
			INT_OE_N_OUT <= 1'b1;
			ARRAY_RESET_OUT <= 1'b0;
			ARRAY_SAMPLE_OUT <= 1'b0;
			PIX_DATA_OUT <= 10'h000;
			LINE_VALID_OUT <= 1'b0;
			FRAME_VALID_OUT <= 1'b0;
		end
		else
		begin
			INT_MAIN_OUT <= int1_d && master_d; // RQ3
			INT_DUAL_OUT <= int2_d && master_d; // RQ5
			INT_TRIPLE_OUT <= int3_d && master_d; // RQ6
			INT_OE_N_OUT <= !master_d; // RQ16
			ARRAY_RESET_OUT <= arr_rst_d; // RQ12
			ARRAY_SAMPLE_OUT <= arr_smp_d; // RQ13
			PIX_DATA_OUT <= (fill_d == 2'h0) ? 10'h000 : b0_d;
			LINE_VALID_OUT <= (fill_d != 2'h0) && frame_d; // RQ1 RQ20
			FRAME_VALID_OUT <= frame_d; // RQ2
		end
	end
endmodule

// ==== verification/ssc_ctrl_model.sv ====
`timescale 1ns/10ps
module ssc_ctrl_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic stall,
	output logic int_main,
	output logic int_dual,
	output logic int_triple,
	output logic rx_ready,
	output logic [9:0] pix
);
	logic [7:0] cnt_q;
	logic tog_q;
	// Window counter; a go pulse opens a 24 cycle slave exposure.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 8'h00;
			tog_q <= 1'b0;
		end
		else
		begin
			tog_q <= ~tog_q;
			if (go)
				cnt_q <= 8'h18;
			else if (cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01;
		end
	end
	// Dual and triple windows sit in the last part of the main one.
	assign int_main = cnt_q != 8'h00;
	assign int_dual = int_main && cnt_q <= 8'h0c;
	assign int_triple = int_main && cnt_q <= 8'h06;
	// A stalling receiver takes a word only every other cycle, so the buffer must hold back.
	assign rx_ready = !stall || tog_q;
	// The pixel word differs between stalled and free runs, so a stale word is caught.
	assign pix = stall ? 10'h2a5 : 10'h15a;
endmodule

// ==== verification/ssc_sva.sv ====
`timescale 1ns/10ps
module ssc_sva
(
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic SEQ_RESET_N_IN,
	input wire logic PARALLEL_MODE_IN,
	input wire logic RX_READY_IN,
	input wire logic INT_MAIN_OUT,
	input wire logic INT_DUAL_OUT,
	input wire logic INT_TRIPLE_OUT,
	input wire logic INT_OE_N_OUT,
	input wire logic ARRAY_RESET_OUT,
	input wire logic ARRAY_SAMPLE_OUT,
	input wire logic [9:0] PIX_DATA_OUT,
	input wire logic LINE_VALID_OUT,
	input wire logic FRAME_VALID_OUT
);
	// Everything is judged on the core clock and silenced by the async reset.
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	line_in_frame_a: assert property (LINE_VALID_OUT |-> FRAME_VALID_OUT)
		else $error("line valid outside frame");
	word_held_a: assert property (LINE_VALID_OUT && !RX_READY_IN && SEQ_RESET_N_IN
		|=> LINE_VALID_OUT && $stable(PIX_DATA_OUT)) else $error("stalled word lost");
	reset_pulse_a: assert property (ARRAY_RESET_OUT |=> !ARRAY_RESET_OUT)
		else $error("array reset too long");
	sample_pulse_a: assert property (ARRAY_SAMPLE_OUT |=> !ARRAY_SAMPLE_OUT)
		else $error("array sample too long");
	slave_quiet_a: assert property (INT_OE_N_OUT |-> !(INT_MAIN_OUT || INT_DUAL_OUT || INT_TRIPLE_OUT))
		else $error("window driven in slave mode");
	dual_inside_a: assert property (INT_DUAL_OUT |-> INT_MAIN_OUT) else $error("dual outside main");
	triple_inside_a: assert property (INT_TRIPLE_OUT |-> INT_DUAL_OUT) else $error("triple outside dual");
	sample_after_main_a: assert property ($fell(INT_MAIN_OUT) && SEQ_RESET_N_IN
		|-> ##[1:2] ARRAY_SAMPLE_OUT) else $error("no sample after window");
	serial_mode_a: assert property (ARRAY_RESET_OUT && !PARALLEL_MODE_IN |-> !FRAME_VALID_OUT)
		else $error("exposure overlaps readout");
endmodule

// ==== verification/ssc_tb_top.sv ====
`timescale 1ns/10ps
module ssc_tb_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic seq_rst_n = 1'b0;
	logic master = 1'b1;
	logic parallel = 1'b0;
	logic go = 1'b0;
	logic stall = 1'b0;
	logic im, idl, itr, rdy, om, od, ot, oe_n, ares, asam, lv, fv;
	logic [9:0] pix, pout;
	int errors = 0;
	int checks = 0;
	// Clock at 10 MHz.
	always #50 clk = ~clk;
	ssc_top #(.ROWS(2), .KERNELS(2), .INT1_TICKS(8), .INT2_TICKS(4),
		.INT3_TICKS(2)) i_ssc_top (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .SEQ_RESET_N_IN(seq_rst_n),
		.MASTER_MODE_IN(master), .PARALLEL_MODE_IN(parallel), .INT_MAIN_IN(im), .INT_DUAL_IN(idl),
		.INT_TRIPLE_IN(itr), .PIX_DATA_IN(pix), .RX_READY_IN(rdy), .INT_MAIN_OUT(om), .INT_DUAL_OUT(od),
		.INT_TRIPLE_OUT(ot), .INT_OE_N_OUT(oe_n), .ARRAY_RESET_OUT(ares), .ARRAY_SAMPLE_OUT(asam),
		.PIX_DATA_OUT(pout), .LINE_VALID_OUT(lv), .FRAME_VALID_OUT(fv));
	ssc_ctrl_model i_ssc_ctrl_model (.clk(clk), .rst_n(arst_n), .go(go), .stall(stall), .int_main(im),
		.int_dual(idl), .int_triple(itr), .rx_ready(rdy), .pix(pix));
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
	begin
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	end
	endtask
	// Modes only change while the sequencer is held in reset.
	task seq_rst(input logic m, input logic p);
	begin
		@(posedge clk);
		seq_rst_n <= 1'b0;
		master <= m;
		parallel <= p;
		repeat (3) @(posedge clk);
		seq_rst_n <= 1'b1;
		@(negedge clk);
	end
	endtask
	// Counts the words taken during one frame and the sample pulse before it.
	task frame(input int exp, input logic [9:0] px);
		int k, w, s;
	begin
		k = 0;
		w = 0;
		s = 0;
		while (fv !== 1'b1 && k < 2000)
		begin
			s += asam;
			@(negedge clk);
			k++;
		end
		while (fv === 1'b1 && k < 4000)
		begin
			if (lv === 1'b1 && rdy === 1'b1)
			begin
				w++;
				chk("pixel", px, pout);
			end
			@(negedge clk);
			k++;
		end
		chk("sample", 1, s);
		chk("words", exp, w);
	end
	endtask
	task t_master;
		int k, n1, n2, n3;
	begin
		seq_rst(1'b1, 1'b0);
		chk("oe", 0, oe_n);
		k = 0;
		n1 = 0;
		n2 = 0;
		n3 = 0;
		while (om !== 1'b1 && k < 200)
		begin
			@(negedge clk);
			k++;
		end
		while (om === 1'b1 && n1 < 200)
		begin
			n1++;
			n2 += od;
			n3 += ot;
			@(negedge clk);
		end
		chk("main", 32, n1);
		chk("dual", 16, n2);
		chk("triple", 8, n3);
		frame(16, 10'h15a);
		$display("master test done");
	end
	endtask
	// Parallel master mode: the next exposure starts while the first frame is still being read.
	task t_overlap;
		int k, r;
	begin
		seq_rst(1'b1, 1'b1);
		k = 0;
		r = 0;
		while (asam !== 1'b1 && k < 400)
		begin
			@(negedge clk);
			k++;
		end
		while (fv !== 1'b1 && k < 1000)
		begin
			r += ares;
			@(negedge clk);
			k++;
		end
		while (fv === 1'b1 && k < 2000)
		begin
			r += ares;
			@(negedge clk);
			k++;
		end
		chk("overlap", 1, r);
		$display("overlap test done");
	end
	endtask
	task t_slave;
		int k;
	begin
		seq_rst(1'b0, 1'b1);
		chk("oe", 1, oe_n);
		@(posedge clk);
		stall <= 1'b1;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		k = 0;
		while (ares !== 1'b1 && k < 40)
		begin
			@(negedge clk);
			k++;
		end
		chk("reset", 1, ares);
		frame(16, 10'h2a5);
		$display("slave test done");
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_master();
		t_overlap();
		t_slave();
		end_of_test();
	end
	// All three tests need well under 2000 cycles, so this only trips on a hang.
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		end_of_test();
	end
endmodule
bind ssc_top ssc_sva i_ssc_sva (.CORE_CLK_IN(CORE_CLK_IN), .ARST_N_IN(ARST_N_IN), .SEQ_RESET_N_IN(SEQ_RESET_N_IN),
	.PARALLEL_MODE_IN(PARALLEL_MODE_IN), .RX_READY_IN(RX_READY_IN), .INT_MAIN_OUT(INT_MAIN_OUT),
	.INT_DUAL_OUT(INT_DUAL_OUT), .INT_TRIPLE_OUT(INT_TRIPLE_OUT), .INT_OE_N_OUT(INT_OE_N_OUT),
	.ARRAY_RESET_OUT(ARRAY_RESET_OUT), .ARRAY_SAMPLE_OUT(ARRAY_SAMPLE_OUT), .PIX_DATA_OUT(PIX_DATA_OUT),
	.LINE_VALID_OUT(LINE_VALID_OUT), .FRAME_VALID_OUT(FRAME_VALID_OUT));
